// ---- logic/boundary_scan_test_port.sv ----
// Boundary-scan test port: instruction and data paths, pin control.
`timescale 1ns/100ps
`include "tap_regs.svh"
module boundary_scan_test_port (
  input wire logic mclk_in, // System clock, 40 MHz.
  input wire logic resetn_in, // Asynchronous reset, active low.
  input wire logic tck_in, // Test clock from the tester.
  input wire logic tms_in, // Test mode select.
  input wire logic tdi_in, // Test serial data in.
  output logic tdo_out, // Test serial data out.
  output logic tdo_oe_out, // Serial out enable, high in shift.
  input wire logic [`PIN_W-1:0] pin_in_in, // Pin levels seen.
  output logic [`PIN_W-1:0] pin_out_out, // Pin drive levels.
  output logic pin_oe_out, // Pin drive enable, high drives.
  input wire logic [`PIN_W-1:0] core_out_in, // Core data to pins.
  input wire logic core_oe_in, // Core pin drive enable.
  output logic [`PIN_W-1:0] core_in_out // Pin levels to the core.
);
  localparam logic [`ID_W-1:0] ID_VALUE =
    {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};

  tap_pkg::tap_state_e state;
  logic [`PIN_W-1:0] pin_s1_reg, pin_s1_next, pin_s2_reg, pin_s2_next;
  logic [`PIN_W:0] core_s1_reg, core_s1_next, core_s2_reg, core_s2_next;
  logic [`IR_W-1:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
  logic [`ID_W-1:0] id_reg, id_next;
  logic byp_reg, byp_next;
  logic ack_s1_reg, ack_s1_next, ack_s2_reg, ack_s2_next;
  logic req_reg, req_next;
  tap_pkg::pin_word_s hold_reg, hold_next, word_now;
  logic sel_bsr, sel_id;
  tap_pkg::dr_ctl_s bsr_ctl;
  logic bsr_so;
  logic [`CELL_W-1:0] bsr_par, bsr_upd;
  logic tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;
  logic req_s1_reg, req_s1_next, req_s2_reg, req_s2_next;
  logic ack_reg, ack_next;
  tap_pkg::pin_word_s word_reg, word_next;
  logic [`PIN_W-1:0] cin_s1_reg, cin_s1_next, cin_s2_reg, cin_s2_next;
  logic [`PIN_W-1:0] pout_reg, pout_next;
  logic poe_reg, poe_next;

  // Controller driven only by mode select, the test clock and the reset.
  tap_fsm u_fsm (
    .tck_in(tck_in),
    .resetn_in(resetn_in),
    .tms_in(tms_in),
    .state_out(state)
  );

  // Decode: path choice and pin mode; spare codes fall to bypass.
  always_comb begin
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    word_now.mode = tap_pkg::PM_NORMAL;
    case (ir_reg)
      `IR_EXTEST: begin
        sel_bsr = 1'b1;
        word_now.mode = tap_pkg::PM_DRIVE;
      end
      `IR_SAMPLE: begin
        sel_bsr = 1'b1;
      end
      `IR_IDCODE: begin
        sel_id = 1'b1;
      end
      `IR_CLAMP: begin
        sel_bsr = 1'b0;
        word_now.mode = tap_pkg::PM_DRIVE;
      end
      `IR_HIGHZ: begin
        word_now.mode = tap_pkg::PM_HIGHZ;
      end
      default: begin
        sel_bsr = 1'b0;
      end
    endcase
    word_now.oe = bsr_upd[`CELL_W-1];
    word_now.dout = bsr_upd[`CELL_W-2:`PIN_W];
  end

  // Chain order from the serial output end: inputs, outputs, enable.
  assign bsr_par = {core_s2_reg, pin_s2_reg};
  assign bsr_ctl.capture = sel_bsr && state == tap_pkg::CAP_DR;
  assign bsr_ctl.shift = sel_bsr && state == tap_pkg::SH_DR;
  // Update only while the chain is selected, so clamp keeps latches.
  assign bsr_ctl.update = sel_bsr && state == tap_pkg::UPD_DR;

  bsr_chain u_bsr (
    .tck_in(tck_in),
    .resetn_in(resetn_in),
    .ctl_in(bsr_ctl),
    .tdi_in(tdi_in),
    .par_in(bsr_par),
    .so_out(bsr_so),
    .upd_out(bsr_upd)
  );

  // Test clock domain: synchronisers, instruction, identity, bypass.
  // Pins and core values come from other domains, hence two stages.
  always_comb begin
    pin_s1_next = pin_in_in;
    pin_s2_next = pin_s1_reg;
    core_s1_next = {core_oe_in, core_out_in};
    core_s2_next = core_s1_reg;
    ack_s1_next = ack_reg;
    ack_s2_next = ack_s1_reg;
    ir_sh_next = ir_sh_reg;
    ir_next = ir_reg;
    id_next = id_reg;
    byp_next = byp_reg;
    req_next = req_reg;
    hold_next = hold_reg;
    case (state)
      tap_pkg::TLR: begin
        ir_next = `IR_IDCODE;
      end
      tap_pkg::CAP_IR: begin
        ir_sh_next = `IR_CAPTURE;
      end
      tap_pkg::SH_IR: begin
        ir_sh_next = {tdi_in, ir_sh_reg[`IR_W-1:1]};
      end
      tap_pkg::UPD_IR: begin
        ir_next = ir_sh_reg;
      end
      tap_pkg::CAP_DR: begin
        id_next = ID_VALUE;
        byp_next = 1'b0;
      end
      tap_pkg::SH_DR: begin
        id_next = {tdi_in, id_reg[`ID_W-1:1]};
        byp_next = tdi_in;
      end
      default: begin
        ir_next = ir_reg;
      end
    endcase
    // Launch a new pin word once the last one has been taken.
    if (req_reg == ack_s2_reg && word_now != hold_reg) begin
      hold_next = word_now;
      req_next = ~req_reg;
    end
  end

  always_ff @(posedge tck_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      core_s1_reg <= '0;
      core_s2_reg <= '0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ir_sh_reg <= `IR_CAPTURE;
      ir_reg <= `IR_IDCODE;
      id_reg <= '0;
      byp_reg <= 1'b0;
      req_reg <= 1'b0;
      hold_reg <= '0;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      core_s1_reg <= core_s1_next;
      core_s2_reg <= core_s2_next;
      ack_s1_reg <= ack_s1_next;
      ack_s2_reg <= ack_s2_next;
      ir_sh_reg <= ir_sh_next;
      ir_reg <= ir_next;
      id_reg <= id_next;
      byp_reg <= byp_next;
      req_reg <= req_next;
      hold_reg <= hold_next;
    end
  end

  // Serial output: the selected register's low bit, shift states only.
  always_comb begin
    tdo_next = 1'b0;
    tdo_oe_next = 1'b0;
    if (state == tap_pkg::SH_IR) begin
      tdo_next = ir_sh_reg[0];
      tdo_oe_next = 1'b1;
    end else if (state == tap_pkg::SH_DR) begin
      tdo_oe_next = 1'b1;
      if (sel_bsr) begin
        tdo_next = bsr_so;
      end else if (sel_id) begin
        tdo_next = id_reg[0];
      end else begin
        tdo_next = byp_reg;
      end
    end
  end

  // Falling edge gives the tester a half period of setup.
  always_ff @(negedge tck_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg;

  // System clock domain: take the pin word, then steer the pins.
  // The held word stays still until acknowledged, so no bit tears.
  always_comb begin
    req_s1_next = req_reg;
    req_s2_next = req_s1_reg;
    ack_next = ack_reg;
    word_next = word_reg;
    cin_s1_next = pin_in_in;
    cin_s2_next = cin_s1_reg;
    if (req_s2_reg != ack_reg) begin
      word_next = hold_reg;
      ack_next = req_s2_reg;
    end
    pout_next = core_out_in;
    poe_next = core_oe_in;
    case (word_reg.mode)
      tap_pkg::PM_DRIVE: begin
        pout_next = word_reg.dout;
        poe_next = word_reg.oe;
      end
      tap_pkg::PM_HIGHZ: begin
        poe_next = 1'b0;
      end
      default: begin
        poe_next = core_oe_in;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_reg <= 1'b0;
      word_reg <= '0;
      cin_s1_reg <= '0;
      cin_s2_reg <= '0;
      pout_reg <= '0;
      poe_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_s1_next;
      req_s2_reg <= req_s2_next;
      ack_reg <= ack_next;
      word_reg <= word_next;
      cin_s1_reg <= cin_s1_next;
      cin_s2_reg <= cin_s2_next;
      pout_reg <= pout_next;
      poe_reg <= poe_next;
    end
  end

  // Core always sees the pins; the capture path never alters them.
  assign core_in_out = cin_s2_reg;
  assign pin_out_out = pout_reg;
  assign pin_oe_out = poe_reg;

  // Checks on the test clock side.
  AST_TMS_RESET: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    tms_in [*5] |=> state == tap_pkg::TLR)
    else $error("Five high mode-select edges did not reach reset.");

  AST_RESET_IR: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    state == tap_pkg::TLR |=> ir_reg == `IR_IDCODE)
    else $error("Reset state did not restore identity instruction.");

  AST_IR_ORDER: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    (state == tap_pkg::SH_IR) [*3] ##1 state == tap_pkg::EX1_IR |->
    ir_sh_reg == {$past(tdi_in, 1), $past(tdi_in, 2), $past(tdi_in, 3)})
    else $error("Instruction bits not shifted least bit first.");

  AST_BYPASS_DELAY: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    (state == tap_pkg::SH_DR && !sel_bsr && !sel_id) ##1
    state == tap_pkg::SH_DR |-> tdo_out == $past(tdi_in))
    else $error("Bypass path delay is not one test clock.");

  AST_ID_SHIFT: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    (state == tap_pkg::CAP_DR && sel_id) ##1
    state == tap_pkg::SH_DR |-> tdo_oe_out && tdo_out == 1'b1)
    else $error("Identity code did not start with a one.");

  AST_TDO_SHIFT_ONLY: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    tdo_oe_out |-> state == tap_pkg::SH_DR || state == tap_pkg::SH_IR)
    else $error("Serial output enabled outside a shift state.");

  AST_CLAMP_STILL: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    ir_reg == `IR_CLAMP && $stable(ir_reg) |-> $stable(bsr_upd))
    else $error("Clamped pin latches changed while scanning.");

  AST_SPARE_BYPASS: assert property (
    @(posedge tck_in) disable iff (!resetn_in)
    ir_reg == `IR_FACTORY || ir_reg == 3'h6 |->
    !sel_bsr && !sel_id && word_now.mode == tap_pkg::PM_NORMAL)
    else $error("Unassigned code did not decode as bypass.");

  // Checks on the system clock side.
  AST_DRIVE_PINS: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    word_reg.mode == tap_pkg::PM_DRIVE ##1
    word_reg.mode == tap_pkg::PM_DRIVE |->
    pin_out_out == $past(word_reg.dout) && pin_oe_out == $past(word_reg.oe))
    else $error("Pins not driven from update latches.");

  AST_HIGHZ_PINS: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    word_reg.mode == tap_pkg::PM_HIGHZ |=> !pin_oe_out)
    else $error("Pin drive enabled under high impedance.");

  AST_SAMPLE_PASS: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    word_reg.mode == tap_pkg::PM_NORMAL |=>
    pin_out_out == $past(core_out_in) && pin_oe_out == $past(core_oe_in))
    else $error("Core values not passed to pins unmodified.");
endmodule

// ---- logic/tap_regs.svh ----
// Constants of the boundary-scan test port.
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH
`define IR_W 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE 3'h2
`define IR_CLAMP 3'h3
`define IR_HIGHZ 3'h4
`define IR_FACTORY 3'h5
`define IR_BYPASS 3'h7
`define IR_CAPTURE 3'h1
`define ID_W 32
// Identity fields; the values are arbitrary.
`define ID_VERSION 4'h1
`define ID_PART 16'h0001
`define ID_MAKER 11'h001
`define PIN_W 8
`define CELL_W 17
`define TMS_RESET_EDGES 5
`endif

// ---- logic/tap_pkg.sv ----
// Types shared by the boundary-scan test port modules.
`include "tap_regs.svh"
package tap_pkg;
  typedef enum logic [3:0] {
    TLR = 4'b0000, RTI = 4'b0001, SEL_DR = 4'b0010, CAP_DR = 4'b0011,
    SH_DR = 4'b0100, EX1_DR = 4'b0101, PA_DR = 4'b0110,
    EX2_DR = 4'b0111, UPD_DR = 4'b1000, SEL_IR = 4'b1001,
    CAP_IR = 4'b1010, SH_IR = 4'b1011, EX1_IR = 4'b1100,
    PA_IR = 4'b1101, EX2_IR = 4'b1110, UPD_IR = 4'b1111
  } tap_state_e;
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00, PM_DRIVE = 2'b01, PM_HIGHZ = 2'b10
  } pin_mode_e;
  typedef struct packed {
    pin_mode_e mode;
    logic oe;
    logic [`PIN_W-1:0] dout;
  } pin_word_s;
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } dr_ctl_s;
endpackage

// ---- logic/tap_fsm.sv ----
// Sixteen-state test controller stepped by the test clock.
`timescale 1ns/100ps
module tap_fsm (
  input wire logic tck_in, // Test clock.
  input wire logic resetn_in, // Asynchronous reset, active low.
  input wire logic tms_in, // Test mode select.
  output tap_pkg::tap_state_e state_out // Current state.
);
  tap_pkg::tap_state_e state_reg;
  tap_pkg::tap_state_e state_next;

  // Every path reaches reset within five high mode-select edges.
  always_comb begin
    state_next = tap_pkg::TLR;
    case (state_reg)
      tap_pkg::TLR: state_next = tms_in ? tap_pkg::TLR : tap_pkg::RTI;
      tap_pkg::RTI: state_next = tms_in ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: state_next = tms_in ? tap_pkg::SEL_IR
                                           : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: state_next = tms_in ? tap_pkg::EX1_DR
                                           : tap_pkg::SH_DR;
      tap_pkg::SH_DR: state_next = tms_in ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: state_next = tms_in ? tap_pkg::UPD_DR
                                           : tap_pkg::PA_DR;
      tap_pkg::PA_DR: state_next = tms_in ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
      tap_pkg::EX2_DR: state_next = tms_in ? tap_pkg::UPD_DR
                                           : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: state_next = tms_in ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: state_next = tms_in ? tap_pkg::TLR : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: state_next = tms_in ? tap_pkg::EX1_IR
                                           : tap_pkg::SH_IR;
      tap_pkg::SH_IR: state_next = tms_in ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: state_next = tms_in ? tap_pkg::UPD_IR
                                           : tap_pkg::PA_IR;
      tap_pkg::PA_IR: state_next = tms_in ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
      tap_pkg::EX2_IR: state_next = tms_in ? tap_pkg::UPD_IR
                                           : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: state_next = tms_in ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default: state_next = tap_pkg::TLR;
    endcase
  end

  // State register; reset lands in test-logic-reset.
  always_ff @(posedge tck_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= tap_pkg::TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_out = state_reg;
endmodule

// ---- logic/bsr_chain.sv ----
// Boundary scan chain: one shift stage and one update latch per cell.
`timescale 1ns/100ps
`include "tap_regs.svh"
module bsr_chain (
  input wire logic tck_in, // Test clock.
  input wire logic resetn_in, // Asynchronous reset, active low.
  input tap_pkg::dr_ctl_s ctl_in, // Capture, shift, update enables.
  input wire logic tdi_in, // Serial data in.
  input wire logic [`CELL_W-1:0] par_in, // Parallel capture values.
  output logic so_out, // Serial out, cell 0.
  output logic [`CELL_W-1:0] upd_out // Latched parallel outputs.
);
  logic [`CELL_W-1:0] sh_reg;
  logic [`CELL_W-1:0] sh_next;
  logic [`CELL_W-1:0] upd_reg;
  logic [`CELL_W-1:0] upd_next;

  // Cell i shifts toward cell 0; the top cell takes serial input.
  genvar i;
  generate
    for (i = 0; i < `CELL_W; i++) begin : g_cell
      logic sin;
      if (i == `CELL_W - 1) begin : g_top
        assign sin = tdi_in;
      end else begin : g_mid
        assign sin = sh_reg[i+1];
      end
      always_comb begin
        sh_next[i] = sh_reg[i];
        upd_next[i] = upd_reg[i];
        if (ctl_in.capture) begin
          sh_next[i] = par_in[i];
        end else if (ctl_in.shift) begin
          sh_next[i] = sin;
        end
        if (ctl_in.update) begin
          upd_next[i] = sh_reg[i];
        end
      end
      always_ff @(posedge tck_in or negedge resetn_in) begin
        if (!resetn_in) begin
          sh_reg[i] <= 1'b0;
          upd_reg[i] <= 1'b0;
        end else begin
          sh_reg[i] <= sh_next[i];
          upd_reg[i] <= upd_next[i];
        end
      end
    end
  endgenerate

  assign so_out = sh_reg[0];
  assign upd_out = upd_reg;
endmodule

// ---- testbench/tap_tester.sv ----
// External test controller model that walks the test port.
`timescale 1ns/100ps
module tap_tester (
  output logic tck_out, // Test clock, still between frames.
  output logic tms_out, // Test mode select.
  output logic tdi_out, // Serial data toward the port.
  input wire logic tdo_in, // Resolved serial data from the port.
  output logic [31:0] res_out, // Bits shifted out in the last scan.
  output logic res_stb_out // Pulses when res_out is fresh.
);
  // Idle levels; the test clock only runs inside a frame.
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
    res_out = '0;
    res_stb_out = 1'b0;
  end

  // One test clock of 12 ns: change after the fall, sample on the rise.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    #1 tms_out = tms;
    tdi_out = tdi;
    #5 tck_out = 1'b1;
    tdo = tdo_in;
    #6 tck_out = 1'b0;
  endtask

  // Five high mode-select edges force the reset state, then idle.
  task automatic reset_walk();
    logic b;
    repeat (5) step(1'b1, ~tdi_out, b);
    step(1'b0, ~tdi_out, b);
  endtask

  // Scan n bits from idle through the instruction or data branch.
  // The unused serial input toggles so a stale level is never trusted.
  task automatic scan(input logic ir, input int n, input logic [31:0] din);
    logic b;
    logic [31:0] dout;
    dout = '0;
    if (ir && n == 3 && din[2:0] == 3'b101) din[2:0] = 3'b111;
    step(1'b1, ~tdi_out, b);
    if (ir) step(1'b1, ~tdi_out, b);
    step(1'b0, ~tdi_out, b);
    step(1'b0, ~tdi_out, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, ~tdi_out, b);
    // Idle clocks let the pin word request launch; the system domain takes it after the frame.
    repeat (5) step(1'b0, ~tdi_out, b);
    res_out = dout;
    res_stb_out = 1'b1;
    #1 res_stb_out = 1'b0;
  endtask
endmodule

// ---- testbench/boundary_scan_test_port_test.sv ----
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/100ps
`include "tap_regs.svh"
module boundary_scan_test_port_test;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [`PIN_W-1:0] core_out_in = '0;
  logic core_oe_in = 1'b0;
  logic [`PIN_W-1:0] ext_pins = '0;
  logic tck, tms, tdi, tdo_out, tdo_oe_out, pin_oe_out, res_stb;
  logic [`PIN_W-1:0] pin_out_out, core_in_out, c, e;
  logic [31:0] res, seed = 32'h7ab6, q, p, d;
  logic [31:0] exp_q[$];
  logic [2:0] codes[2] = '{3'h6, 3'h4};
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Serial out floats unless enabled; pins resolve from both drivers.
  wire tdo_w = tdo_oe_out ? tdo_out : 1'bz;
  wire [`PIN_W-1:0] pin_w = pin_oe_out ? pin_out_out : ext_pins;

  always #12.5 mclk_in = ~mclk_in;

  boundary_scan_test_port boundary_scan_test_port_inst (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out), .pin_in_in(pin_w),
    .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out),
    .core_out_in(core_out_in), .core_oe_in(core_oe_in),
    .core_in_out(core_in_out)
  );

  tap_tester tap_tester_inst (
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_w),
    .res_out(res), .res_stb_out(res_stb)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Core and far-side pin values change just after the system clock.
  task automatic set_core(input logic [7:0] v, input logic oe);
    @(posedge mclk_in);
    #2 core_out_in = v;
    core_oe_in = oe;
    ext_pins = ~v;
  endtask

  // Pins settle through the handshake; allow ten system clocks.
  task automatic chk_pins(input logic oe, input logic [7:0] v);
    repeat (10) @(posedge mclk_in);
    #2 check(32'({pin_oe_out, pin_out_out}), 32'({oe, v}));
  endtask

  // An instruction load always reads back the fixed capture pattern.
  task automatic ir(input logic [2:0] code);
    exp_q.push_back(32'h1);
    tap_tester_inst.scan(1'b1, 3, 32'(code));
  endtask

  // Bypass path: a captured zero, then the input one clock late.
  task automatic dr_byp();
    d = rnd();
    exp_q.push_back({24'h0, d[6:0], 1'b0});
    tap_tester_inst.scan(1'b0, 8, d);
  endtask

  // Each finished scan is compared with the oldest expectation noted.
  always @(posedge res_stb) begin
    if (exp_q.size() == 0) begin
      failures++;
      $display("ERROR %0t: scan result with nothing expected", $time);
    end else begin
      check(res, exp_q.pop_front());
    end
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      $display("ERROR %0t: run did not finish", $time);
      results();
    end
  end

  initial begin
    repeat (4) @(posedge mclk_in);
    #2 resetn_in = 1'b1;
    #3;
    c = rnd();
    set_core(c[7:0], 1'b1);
    chk_pins(1'b1, c[7:0]);
    // Reset leaves the controller in its reset state; scans start in idle.
    tap_tester_inst.reset_walk();
    exp_q.push_back({`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
    tap_tester_inst.scan(1'b0, 32, rnd());
    ir(3'h7);
    dr_byp();
    foreach (codes[i]) begin
      ir(codes[i]);
      dr_byp();
      if (codes[i] == 3'h4) chk_pins(1'b0, c[7:0]);
    end
    ir(3'h2);
    chk_pins(1'b1, c[7:0]);
    q = rnd();
    q[16] = 1'b0;
    exp_q.push_back({15'h0, 1'b1, c[7:0], c[7:0]});
    tap_tester_inst.scan(1'b0, 17, q);
    chk_pins(1'b1, c[7:0]);
    ir(3'h0);
    e = ext_pins;
    chk_pins(1'b0, q[15:8]);
    p = rnd();
    p[16] = 1'b1;
    exp_q.push_back({15'h0, 1'b1, c[7:0], e});
    tap_tester_inst.scan(1'b0, 17, p);
    chk_pins(1'b1, p[15:8]);
    check(32'(core_in_out), 32'(p[15:8]));
    ir(3'h3);
    set_core(~c[7:0], 1'b1);
    dr_byp();
    chk_pins(1'b1, p[15:8]);
    tap_tester_inst.reset_walk();
    chk_pins(1'b1, ~c[7:0]);
    exp_q.push_back({`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
    tap_tester_inst.scan(1'b0, 32, rnd());
    #20;
    // A note left in the queue means a scan result never arrived.
    if (exp_q.size() != 0) begin
      failures++;
      $display("ERROR %0t: expected scan results missing", $time);
    end
    results();
  end
endmodule
